/* File: shared/ext_start_stop_defines.vh */
// Constants for the external start/stop control block
`ifndef EXT_START_STOP_DEFINES_VH
`define EXT_START_STOP_DEFINES_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_PINSEL 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10

// Control register fields
`define CTRL_SRC_LSB 0
`define CTRL_SRC_MSB 1
`define CTRL_ILOCK_EN 2
`define CTRL_TEST_PER_STEP 3
`define CTRL_JUDGE_PER_STEP 4
`define CTRL_RESET 32'h00000000

// Control source encodings
`define SRC_FRONT 2'h0
`define SRC_REMOTE 2'h1
`define SRC_SIGNAL 2'h2

// Status pin condition codes, three bits per pin
`define COND_READY 3'h0
`define COND_TESTING 3'h1
`define COND_PASS 3'h2
`define COND_FAIL 3'h3
`define COND_FAIL_HI 3'h4
`define COND_FAIL_LO 3'h5
`define PINSEL_RESET 32'h00005688

// Interrupt bits
`define IRQ_START 0
`define IRQ_STOP 1
`define IRQ_DONE 2
`define IRQ_ILOCK 3
`define IRQ_MASK_RESET 32'h00000000

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Minimum contact hold: 1 ms of the 40 MHz reference clock, sized to
// the 16-bit qualifier counter
`define HOLD_CYCLES 16'd40000

`endif

/* File: src/contact_qualifier.v */
// Synchroniser and minimum-hold qualifier for one active-low contact input
module contact_qualifier #(
	parameter [15:0] HOLD = 16'd40000
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	input wire i_ce,
	// Contact, low while shorted to its return
	input wire i_pin_n,
	// Qualified results
	output reg o_held,
	output reg o_press
);
	reg meta;
	reg sync;
	reg [15:0] cnt;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= 1'b1;
			sync <= 1'b1;
			cnt <= 16'h0000;
			o_held <= 1'b0;
			o_press <= 1'b0;
		end else if (i_ce) begin
			meta <= i_pin_n;
			sync <= meta;
			o_press <= 1'b0;
			if (sync) begin
				cnt <= 16'h0000;
				o_held <= 1'b0;
			end else if (cnt < HOLD - 16'h0001) begin
				cnt <= cnt + 16'h0001;
			end else if (!o_held) begin
				// A short glitch never reaches here: the count restarts
				o_held <= 1'b1;
				o_press <= 1'b1;
			end
		end
	end
endmodule

/* File: src/ext_start_stop_ctrl.v */
// External start/stop control with interlock, status pins and AXI4-Lite
//
// Behaviour
// - Remote terminal acts like front-panel buttons
// - Remote selected: starts only from remote terminal
// - Front-panel stop always aborts a running test
// - Front panel selected: remote start ignored
// - Signal-port inputs honoured only when selected
// - Signal-port stop held 1ms gives ready
// - Signal-port start held 1ms starts test
// - Signal-port stop during test stops it
// - Interlock enabled: start only with loop closed
// - Five status outputs drive test status
// - Each output selects one of six conditions
// - Testing indication continuous or per step
// - Judgement after final step or each step
// - Open interlock refuses start, flags condition
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`include "ext_start_stop_defines.vh"

module ext_start_stop_ctrl #(
	parameter [15:0] HOLD_CYCLES = `HOLD_CYCLES
) (
	// Clock, reset, clock enable
	input wire I_REF_CLK,
	input wire I_RESETN,
	input wire I_CE,
	// Contact inputs, low while shorted to their return
	input wire I_PANEL_START_N,
	input wire I_PANEL_STOP_N,
	input wire I_REMOTE_GO_IN_N,
	input wire I_REMOTE_HALT_IN_N,
	input wire I_PORT_START_N,
	input wire I_PORT_STOP_N,
	input wire I_SAFETY_LOOP_B_N,
	// Test engine, same clock
	input wire I_AUTO_MODE,
	input wire I_STEP_START,
	input wire I_STEP_DONE,
	input wire I_TEST_DONE,
	input wire I_RESULT_PASS,
	input wire I_RESULT_FAIL_HI,
	input wire I_RESULT_FAIL_LO,
	output reg O_TEST_START,
	output reg O_TEST_ABORT,
	// Status port and flags
	output reg [4:0] O_STATUS_OUT,
	output reg O_INTERLOCK_OPEN,
	output reg O_IRQ,
	// AXI4-Lite slave
	input wire [7:0] I_AWADDR,
	input wire I_AWVALID,
	output reg O_AWREADY,
	input wire [31:0] I_WDATA,
	input wire [3:0] I_WSTRB,
	input wire I_WVALID,
	output reg O_WREADY,
	output reg [1:0] O_BRESP,
	output reg O_BVALID,
	input wire I_BREADY,
	input wire [7:0] I_ARADDR,
	input wire I_ARVALID,
	output reg O_ARREADY,
	output reg [31:0] O_RDATA,
	output reg [1:0] O_RRESP,
	output reg O_RVALID,
	input wire I_RREADY
);
	localparam [2:0] ST_READY = 3'b001;
	localparam [2:0] ST_TEST = 3'b010;
	localparam [2:0] ST_JUDGED = 3'b100;

	reg rst_meta;
	reg rst_n;
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Contacts: 0 panel start, 1 panel stop, 2 remote go, 3 remote halt,
	// 4 port start, 5 port stop
	wire [5:0] pins_n;
	wire [5:0] held;
	wire [5:0] press;
	assign pins_n = {I_PORT_STOP_N, I_PORT_START_N, I_REMOTE_HALT_IN_N,
		I_REMOTE_GO_IN_N, I_PANEL_STOP_N, I_PANEL_START_N};

	genvar c;
	generate
		for (c = 0; c < 6; c = c + 1) begin : g_contact
			contact_qualifier #(
				.HOLD(HOLD_CYCLES)
			) u_qual (
				.i_clk(I_REF_CLK),
				.i_rst_n(rst_n),
				.i_ce(I_CE),
				.i_pin_n(pins_n[c]),
				.o_held(held[c]),
				.o_press(press[c])
			);
		end
	endgenerate

	reg loop_meta;
	reg loop_closed;
	always @(posedge I_REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			loop_meta <= 1'b0;
			loop_closed <= 1'b0;
		end else if (I_CE) begin
			loop_meta <= ~I_SAFETY_LOOP_B_N;
			loop_closed <= loop_meta;
		end
	end

	reg [31:0] ctrl;
	reg [31:0] pinsel;
	reg [31:0] irq_mask;
	reg [3:0] irq_stat;
	wire [1:0] src;
	assign src = ctrl[`CTRL_SRC_MSB:`CTRL_SRC_LSB];

	reg start_req;
	reg stop_req;
	always @* begin
		start_req = 1'b0;
		stop_req = press[1];
		case (src)
			`SRC_FRONT: begin
				start_req = press[0];
			end
			`SRC_REMOTE: begin
				start_req = press[2];
				stop_req = press[1] | press[3];
			end
			`SRC_SIGNAL: begin
				start_req = press[4];
				stop_req = press[1] | press[5];
			end
			default: begin
				start_req = 1'b0;
			end
		endcase
	end

	reg [2:0] state;
	reg step_active;
	reg judged_pass;
	reg judged_hi;
	reg judged_lo;
	reg judge_valid;
	reg ev_start;
	reg ev_stop;
	reg ev_done;
	reg ev_ilock;
	wire ilock_ok;
	wire per_step_judge;
	assign ilock_ok = ~ctrl[`CTRL_ILOCK_EN] | loop_closed;
	assign per_step_judge = I_AUTO_MODE & ctrl[`CTRL_JUDGE_PER_STEP];

	always @(posedge I_REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_READY;
			step_active <= 1'b0;
			judged_pass <= 1'b0;
			judged_hi <= 1'b0;
			judged_lo <= 1'b0;
			judge_valid <= 1'b0;
			O_TEST_START <= 1'b0;
			O_TEST_ABORT <= 1'b0;
			O_INTERLOCK_OPEN <= 1'b0;
			ev_start <= 1'b0;
			ev_stop <= 1'b0;
			ev_done <= 1'b0;
			ev_ilock <= 1'b0;
		end else if (I_CE) begin
			O_TEST_START <= 1'b0;
			O_TEST_ABORT <= 1'b0;
			ev_start <= 1'b0;
			ev_stop <= 1'b0;
			ev_done <= 1'b0;
			ev_ilock <= 1'b0;
			if (stop_req) begin
				// Stop is checked first so it beats a start in the same cycle
				O_TEST_ABORT <= state[1];
				state <= ST_READY;
				step_active <= 1'b0;
				judge_valid <= 1'b0;
				O_INTERLOCK_OPEN <= 1'b0;
				ev_stop <= 1'b1;
			end else begin
				case (state)
					ST_READY: begin
						if (start_req && !ilock_ok) begin
							O_INTERLOCK_OPEN <= 1'b1;
							ev_ilock <= 1'b1;
						end else if (start_req) begin
							state <= ST_TEST;
							O_TEST_START <= 1'b1;
							O_INTERLOCK_OPEN <= 1'b0;
							step_active <= 1'b1;
							judge_valid <= 1'b0;
							ev_start <= 1'b1;
						end
					end
					ST_TEST: begin
						if (I_STEP_START) begin
							step_active <= 1'b1;
						end
						if (I_STEP_DONE) begin
							step_active <= 1'b0;
						end
						if (I_TEST_DONE || (I_STEP_DONE && per_step_judge)) begin
							judged_pass <= I_RESULT_PASS;
							judged_hi <= I_RESULT_FAIL_HI;
							judged_lo <= I_RESULT_FAIL_LO;
							judge_valid <= 1'b1;
						end else if (I_STEP_START && per_step_judge) begin
							judge_valid <= 1'b0;
						end
						if (I_TEST_DONE) begin
							state <= ST_JUDGED;
							step_active <= 1'b0;
							ev_done <= 1'b1;
						end
					end
					ST_JUDGED: begin
						// A finished test waits for a stop before the next start
						state <= ST_JUDGED;
					end
					default: begin
						state <= ST_READY;
					end
				endcase
			end
		end
	end

	wire testing_ind;
	assign testing_ind = (I_AUTO_MODE && ctrl[`CTRL_TEST_PER_STEP]) ?
		(state[1] & step_active) : state[1];

	wire [5:0] cond;
	assign cond = {judge_valid & judged_lo, judge_valid & judged_hi,
		judge_valid & ~judged_pass, judge_valid & judged_pass,
		testing_ind, state[0]};

	genvar p;
	generate
		for (p = 0; p < 5; p = p + 1) begin : g_status
			wire [2:0] sel;
			assign sel = pinsel[3 * p + 2:3 * p];
			always @(posedge I_REF_CLK or negedge rst_n) begin
				if (!rst_n) begin
					O_STATUS_OUT[p] <= 1'b0;
				end else if (I_CE) begin
					// Codes above the six conditions leave the pin off
					O_STATUS_OUT[p] <= (sel < 3'h6) ? cond[sel] : 1'b0;
				end
			end
		end
	endgenerate

	// AXI4-Lite slave: one write and one read held at a time
	reg aw_got;
	reg w_got;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire [31:0] wmask;
	wire rd_irq;
	assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
		{8{w_strb[0]}}};
	assign rd_irq = O_ARREADY && I_ARVALID && I_ARADDR == `OFS_IRQ_STAT;

	always @(posedge I_REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			O_AWREADY <= 1'b1;
			O_WREADY <= 1'b1;
			O_BVALID <= 1'b0;
			O_BRESP <= `RESP_OKAY;
			ctrl <= `CTRL_RESET;
			pinsel <= `PINSEL_RESET;
			irq_mask <= `IRQ_MASK_RESET;
		end else if (I_CE) begin
			if (O_AWREADY && I_AWVALID) begin
				aw_got <= 1'b1;
				aw_addr <= I_AWADDR;
				O_AWREADY <= 1'b0;
			end
			if (O_WREADY && I_WVALID) begin
				w_got <= 1'b1;
				w_data <= I_WDATA;
				w_strb <= I_WSTRB;
				O_WREADY <= 1'b0;
			end
			if (aw_got && w_got && !O_BVALID) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= `RESP_OKAY;
				case (aw_addr)
					`OFS_CTRL: ctrl <= (ctrl & ~wmask) | (w_data & wmask);
					`OFS_PINSEL: pinsel <= (pinsel & ~wmask) | (w_data & wmask);
					`OFS_IRQ_MASK: irq_mask <= (irq_mask & ~wmask) |
						(w_data & wmask);
					`OFS_STATUS: O_BRESP <= `RESP_OKAY;
					`OFS_IRQ_STAT: O_BRESP <= `RESP_OKAY;
					default: O_BRESP <= `RESP_SLVERR;
				endcase
			end
			if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
				O_AWREADY <= 1'b1;
				O_WREADY <= 1'b1;
			end
		end
	end

	always @(posedge I_REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h00000000;
			O_RRESP <= `RESP_OKAY;
		end else if (I_CE) begin
			if (O_ARREADY && I_ARVALID) begin
				O_ARREADY <= 1'b0;
				O_RVALID <= 1'b1;
				O_RRESP <= `RESP_OKAY;
				case (I_ARADDR)
					`OFS_CTRL: O_RDATA <= {27'h0000000, ctrl[4:0]};
					`OFS_PINSEL: O_RDATA <= {17'h00000, pinsel[14:0]};
					`OFS_STATUS: O_RDATA <= {22'h000000, O_INTERLOCK_OPEN,
						O_STATUS_OUT, loop_closed, state};
					`OFS_IRQ_STAT: O_RDATA <= {28'h0000000, irq_stat};
					`OFS_IRQ_MASK: O_RDATA <= {28'h0000000, irq_mask[3:0]};
					default: begin
						O_RDATA <= 32'h00000000;
						O_RRESP <= `RESP_SLVERR;
					end
				endcase
			end
			if (O_RVALID && I_RREADY) begin
				O_RVALID <= 1'b0;
				O_ARREADY <= 1'b1;
			end
		end
	end

	// Read clears the sticky bits, but an event in that cycle survives
	wire [3:0] events;
	assign events = {ev_ilock, ev_done, ev_stop, ev_start};
	always @(posedge I_REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= 4'h0;
			O_IRQ <= 1'b0;
		end else if (I_CE) begin
			irq_stat <= (rd_irq ? 4'h0 : irq_stat) | events;
			O_IRQ <= |(((rd_irq ? 4'h0 : irq_stat) | events) & irq_mask[3:0]);
		end
	end
endmodule

/* File: sim/ext_start_stop_checker.sv */
// Port assertions for the external start/stop control block
module ext_start_stop_checker #(
	parameter [15:0] HOLD_CYCLES = 16'd8
) (
	// Clock and reset
	input wire I_REF_CLK,
	input wire I_RESETN,
	// Contacts
	input wire I_PANEL_START_N,
	input wire I_PANEL_STOP_N,
	input wire I_REMOTE_GO_IN_N,
	input wire I_REMOTE_HALT_IN_N,
	input wire I_PORT_START_N,
	input wire I_PORT_STOP_N,
	// Test engine
	input wire O_TEST_START,
	input wire O_TEST_ABORT,
	// Register bus
	input wire I_AWVALID,
	input wire O_AWREADY,
	input wire I_WVALID,
	input wire O_WREADY,
	input wire [1:0] O_BRESP,
	input wire O_BVALID,
	input wire I_BREADY,
	input wire I_ARVALID,
	input wire O_ARREADY,
	input wire [31:0] O_RDATA,
	input wire O_RVALID,
	input wire I_RREADY
);
	// Cycles any start or stop contact has been held shorted
	logic [15:0] go_cnt;
	logic [15:0] halt_cnt;
	always @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			go_cnt <= 16'h0;
			halt_cnt <= 16'h0;
		end else begin
			go_cnt <= (I_PANEL_START_N & I_REMOTE_GO_IN_N & I_PORT_START_N) ?
				16'h0 : go_cnt + 16'h1;
			halt_cnt <= (I_PANEL_STOP_N & I_REMOTE_HALT_IN_N & I_PORT_STOP_N) ?
				16'h0 : halt_cnt + 16'h1;
		end
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);
	sequence wr_taken;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
	endsequence
	sequence rd_taken;
		I_ARVALID && O_ARREADY;
	endsequence
	// Two cycles of slack cover the synchroniser latency
	go_hold_a: assert property (
		O_TEST_START |-> $past(go_cnt, 4) >= HOLD_CYCLES - 16'd2)
		else $error("test start without a long enough press");
	halt_hold_a: assert property (
		O_TEST_ABORT |-> $past(halt_cnt, 4) >= HOLD_CYCLES - 16'd2)
		else $error("abort without a long enough press");
	go_pulse_a: assert property (
		O_TEST_START |=> !O_TEST_START && !O_TEST_ABORT)
		else $error("start pulse too long");
	halt_pulse_a: assert property (
		O_TEST_ABORT |=> !O_TEST_ABORT)
		else $error("abort pulse too long");
	stop_wins_a: assert property (
		!(O_TEST_START && O_TEST_ABORT))
		else $error("start and abort together");
	wr_resp_a: assert property (wr_taken |-> ##[1:2] O_BVALID)
		else $error("write response missing");
	b_hold_a: assert property (
		O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write response dropped");
	rd_resp_a: assert property (rd_taken |-> ##[1:2] O_RVALID)
		else $error("read response missing");
	r_hold_a: assert property (
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data dropped");
endmodule

bind ext_start_stop_ctrl ext_start_stop_checker #(
	.HOLD_CYCLES(HOLD_CYCLES)
) chk (.I_REF_CLK, .I_RESETN, .I_PANEL_START_N, .I_PANEL_STOP_N,
	.I_REMOTE_GO_IN_N, .I_REMOTE_HALT_IN_N, .I_PORT_START_N, .I_PORT_STOP_N,
	.O_TEST_START, .O_TEST_ABORT, .I_AWVALID, .O_AWREADY, .I_WVALID,
	.O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY,
	.O_RDATA, .O_RVALID, .I_RREADY);

/* File: sim/fixture_ctrl.sv */
// Fixture controller model driving the contact lines
module fixture_ctrl (
	input wire logic clk,
	output logic [6:0] pins_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins_n = 7'h7f;
	// Short one contact to its return for len cycles
	task automatic press(input int idx, input int len);
		pins_n[idx] <= 1'b0;
		repeat (len) @(posedge clk);
		pins_n[idx] <= 1'b1;
	endtask
	task automatic loop_set(input logic closed);
		pins_n[6] <= !closed;
	endtask
endmodule

/* File: sim/test_external_test_start_stop_control.sv */
// Self-checking bench for the external start/stop control block
`include "ext_start_stop_defines.vh"
module test_external_test_start_stop_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 8;
	localparam int LEN = HOLD + 6;
	localparam int PST = 0, PSP = 1, RGO = 2, RHT = 3, GST = 4, GSP = 5;
	logic clk = 1'b0, rstn = 1'b0, done = 1'b0, fhi = 1'b0, flo = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic rpass = 1'b0, amode = 1'b0, sstart = 1'b0, sdone = 1'b0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [6:0] pn;
	wire st, ab, ilo, irq, awr, wr, bv, arr, rv;
	wire [4:0] so;
	wire [1:0] br, rr;
	wire [31:0] rdata;
	int num_errors = 0, check_count = 0, cyc = 0, ns = 0, na = 0;
	always #12.5 clk = ~clk;
	fixture_ctrl fx (.clk(clk), .pins_n(pn));
	ext_start_stop_ctrl #(.HOLD_CYCLES(16'd8)) DUT (
		.I_REF_CLK(clk), .I_RESETN(rstn), .I_CE(1'b1),
		.I_PANEL_START_N(pn[0]), .I_PANEL_STOP_N(pn[1]),
		.I_REMOTE_GO_IN_N(pn[2]), .I_REMOTE_HALT_IN_N(pn[3]),
		.I_PORT_START_N(pn[4]), .I_PORT_STOP_N(pn[5]),
		.I_SAFETY_LOOP_B_N(pn[6]), .I_AUTO_MODE(amode), .I_STEP_START(sstart),
		.I_STEP_DONE(sdone), .I_TEST_DONE(done), .I_RESULT_PASS(rpass),
		.I_RESULT_FAIL_HI(fhi), .I_RESULT_FAIL_LO(flo),
		.O_TEST_START(st), .O_TEST_ABORT(ab), .O_STATUS_OUT(so),
		.O_INTERLOCK_OPEN(ilo), .O_IRQ(irq),
		.I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wr),
		.O_BRESP(br), .O_BVALID(bv), .I_BREADY(bready),
		.I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arr),
		.O_RDATA(rdata), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rready));
	task end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (st === 1'b1) ns <= ns + 1;
		if (ab === 1'b1) na <= na + 1;
		if (cyc == 5000) begin
			num_errors++;
			end_sim();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		fork
			begin do @(posedge clk); while (awr !== 1'b1); awv <= 1'b0; end
			begin do @(posedge clk); while (wr !== 1'b1); wv <= 1'b0; end
		join
		bready <= 1'b1;
		do @(posedge clk); while (bv !== 1'b1);
		chk(br, er);
		bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		araddr <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rv !== 1'b1);
		chk(rdata, ed);
		chk(rr, er);
		rready <= 1'b0;
	endtask
	// Press a contact and count the start and abort pulses it causes
	task automatic act(input int idx, input int len, input int es,
		input int ea);
		int s0, a0;
		s0 = ns;
		a0 = na;
		fx.press(idx, len);
		repeat (4) @(posedge clk);
		chk(ns - s0, es);
		chk(na - a0, ea);
	endtask
	// One-cycle test engine strobes with the result levels beside them
	task automatic eng(input logic s, input logic d, input logic t,
		input logic p, input logic hi, input logic lo);
		sstart <= s;
		sdone <= d;
		done <= t;
		rpass <= p;
		fhi <= hi;
		flo <= lo;
		@(posedge clk);
		sstart <= 1'b0;
		sdone <= 1'b0;
		done <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task t_regs();
		rd_reg(`OFS_CTRL, `CTRL_RESET, `RESP_OKAY);
		rd_reg(`OFS_PINSEL, `PINSEL_RESET, `RESP_OKAY);
		rd_reg(`OFS_IRQ_MASK, `IRQ_MASK_RESET, `RESP_OKAY);
		rd_reg(8'h40, 32'h0, `RESP_SLVERR);
		wr_reg(8'h40, 32'h1, `RESP_SLVERR);
		wr_reg(`OFS_STATUS, 32'hffff, `RESP_OKAY);
		rd_reg(`OFS_STATUS, 32'h11, `RESP_OKAY);
		$display("regs test done");
	endtask
	task t_irq();
		wr_reg(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY);
		act(PST, LEN, 1, 0);
		chk(irq, 1'b1);
		rd_reg(`OFS_IRQ_STAT, 32'h1, `RESP_OKAY);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		act(PSP, LEN, 0, 1);
		chk(irq, 1'b0);
		rd_reg(`OFS_IRQ_STAT, 32'h2, `RESP_OKAY);
		$display("irq test done");
	endtask
	task t_signal();
		wr_reg(`OFS_CTRL, 32'h6, `RESP_OKAY);
		act(GST, LEN, 0, 0);
		chk(ilo, 1'b1);
		rd_reg(`OFS_IRQ_STAT, 32'h8, `RESP_OKAY);
		fx.loop_set(1'b1);
		act(GSP, LEN, 0, 0);
		chk(ilo, 1'b0);
		act(GST, LEN, 1, 0);
		act(GSP, LEN, 0, 1);
		act(GST, LEN, 1, 0);
		act(PSP, LEN, 0, 1);
		$display("signal port test done");
	endtask
	task t_remote();
		wr_reg(`OFS_CTRL, 32'h1, `RESP_OKAY);
		act(PST, LEN, 0, 0);
		act(RGO, LEN, 1, 0);
		act(RHT, LEN, 0, 1);
		act(RGO, LEN, 1, 0);
		act(GSP, LEN, 0, 0);
		act(PSP, LEN, 0, 1);
		$display("remote test done");
	endtask
	task t_front();
		wr_reg(`OFS_CTRL, 32'h0, `RESP_OKAY);
		act(RGO, LEN, 0, 0);
		act(GST, LEN, 0, 0);
		act(PST, HOLD - 2, 0, 0);
		act(PST, LEN, 1, 0);
		act(PST, LEN, 0, 0);
		act(PSP, LEN, 0, 1);
		act(PSP, LEN, 0, 0);
		$display("front panel test done");
	endtask
	task t_status();
		chk(so, 5'h01);
		act(PST, LEN, 1, 0);
		chk(so, 5'h02);
		eng(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		chk(so, 5'h18);
		act(PSP, LEN, 0, 0);
		chk(so, 5'h01);
		wr_reg(`OFS_PINSEL, 32'h7ffc, `RESP_OKAY);
		act(PST, LEN, 1, 0);
		chk(so, 5'h00);
		eng(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		chk(so, 5'h01);
		act(PSP, LEN, 0, 0);
		$display("status test done");
	endtask
	// Pins: 0 testing, 1 pass, 2 fail, 3 and 4 off
	task t_auto();
		wr_reg(`OFS_PINSEL, 32'h7ed1, `RESP_OKAY);
		wr_reg(`OFS_CTRL, 32'h10, `RESP_OKAY);
		amode <= 1'b1;
		act(PST, LEN, 1, 0);
		chk(so, 5'h01);
		eng(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		chk(so, 5'h03);
		wr_reg(`OFS_CTRL, 32'h18, `RESP_OKAY);
		eng(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(so, 5'h01);
		eng(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(so, 5'h04);
		eng(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		chk(so, 5'h02);
		act(PSP, LEN, 0, 0);
		amode <= 1'b0;
		$display("auto sequence test done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_irq();
		t_signal();
		t_remote();
		t_front();
		t_status();
		t_auto();
		end_sim();
	end
endmodule
